// ### src/option_regs_pkg.sv
// shared constants for the write-once option register bank
package option_regs_pkg;

  // register addresses on the core bus
  localparam logic [15:0] OPT_ONE_ADDR = 16'h001E;
  localparam logic [15:0] OPT_TWO_ADDR = 16'h001F;

  // data width of each option register
  localparam int DATA_W = 8;

  // reset value of every option latch
  localparam logic [7:0] OPT_RESET_VAL = 8'h00;
  localparam logic [7:0] READ_UNMAPPED = 8'h00;

  // option_reg_one field positions
  localparam int WD_RATE_BIT = 7;  // watchdog_rate_sel
  localparam int LV_STOP_BIT = 6;  // monitor enabled in stop
  localparam int LV_RSTD_BIT = 5;  // monitor reset disable
  localparam int LV_PWRD_BIT = 4;  // monitor power disable
  localparam int LV_MODE_BIT = 3;  // lowvolt_mode_sel
  localparam int SHORT_REC_BIT = 2;  // short_recovery_sel
  localparam int STOP_EN_BIT = 1;  // stop instruction enable
  localparam int WD_DIS_BIT = 0;  // watchdog disable

  // option_reg_two field positions
  localparam int CLK_SRC_BIT = 7;  // clkout_source_sel
  localparam int CLK_DIV_HI_BIT = 6;  // clkout_div_hi
  localparam int CLK_DIV_LO_BIT = 5;  // clkout_div_lo
  localparam int TB_PRESC_BIT = 3;  // timebase extra prescaler
  localparam int OSC_STOP_BIT = 1;  // oscillator runs in stop
  localparam int SCI_SRC_BIT = 0;  // serial baud clock source

  // implemented bits, the rest read as zero
  localparam logic [7:0] OPT_TWO_MASK = 8'hEB;

  // clock output divide codes {clkout_div_hi, clkout_div_lo}
  localparam logic [1:0] CLKOUT_OFF = 2'h0;
  localparam logic [1:0] CLKOUT_DIV1 = 2'h1;
  localparam logic [1:0] CLKOUT_DIV2 = 2'h2;
  localparam logic [1:0] CLKOUT_DIV4 = 2'h3;

  // stop exit delays in osc_clock cycles
  localparam logic [12:0] STOP_REC_SHORT = 13'd32;
  localparam logic [12:0] STOP_REC_LONG = 13'd4096;

  // watchdog timeouts in osc_clock cycles
  localparam logic [17:0] WD_TIMEOUT_FAST = 18'd8176;
  localparam logic [17:0] WD_TIMEOUT_SLOW = 18'd262128;

endpackage : option_regs_pkg

// ### src/write_once_option_registers.sv
// write-once option register bank with clock output divider
//
// Operation
// - each register takes one write per reset
// - reset clears option latches to defaults
// - registers at 001E and 001F, always readable
// - voltage-mode bit written once per power-on
// - clock source one crystal, zero bus
// - option bit picks short or long stop delay
// - option bit picks watchdog timeout length
// - clock output divides by one, two, four
// - divide code 00 off,01 x1,10 /2,11 /4
// - short recovery 32, otherwise 4096 cycles
// - rate bit 1 gives 8176, else 262128
//
// the voltage mode bit keeps its own power-on reset domain, so a plain
// reset reloads every other option but leaves that bit and its lock;
// reads never touch a lock, so software may poll the bank at any time
//
// Our own choices: the address map and the address-and-strobe port.
`timescale 1ns/1ns
module write_once_option_registers
  import option_regs_pkg::*;
#(
  parameter int ADDR_W = 16
) (
  // clock, resets and clock enable
  input wire logic clk,
  input wire logic arst_n,
  input wire logic por_arst_n,
  input wire logic ce,
  // register port
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [DATA_W-1:0] rdata,
  // clock sources for the clock output, same-clock enable pulses
  input wire logic osc_tick,
  input wire logic bus_tick,
  // option_reg_one fields
  output logic watchdog_rate_sel,
  output logic lowvolt_stop_en,
  output logic lowvolt_reset_dis,
  output logic lowvolt_power_dis,
  output logic lowvolt_mode_sel,
  output logic short_recovery_sel,
  output logic stop_insn_en,
  output logic watchdog_dis,
  // option_reg_two fields
  output logic clkout_source_sel,
  output logic clkout_div_hi,
  output logic clkout_div_lo,
  output logic timebase_presc_en,
  output logic osc_in_stop_en,
  output logic sci_clk_src_sel,
  // derived delays in osc_clock cycles
  output logic [12:0] stop_recovery_cycles,
  output logic [17:0] watchdog_timeout_cycles,
  // write-once status
  output logic opt_one_locked,
  output logic opt_two_locked,
  // clock output enable pulse
  output logic clkout_tick
);

  // refuse an address bus too narrow for the map
  // five bits reach both register addresses; sixteen is the full map
  if (ADDR_W < 5 || ADDR_W > 16) begin : g_addr_chk
    $error("ADDR_W must be between 5 and 16");
  end

  // compare a bus address against a map entry
  function automatic logic addr_hit(input logic [ADDR_W-1:0] a,
                                    input logic [15:0] reg_addr);
    logic [15:0] wide;  // bus address zero-extended to the map width
    wide = 16'(a);
    addr_hit = (wide == reg_addr);
  endfunction : addr_hit

  // a write lands only while its target has not been written yet
  function automatic logic write_open(input logic strobe,
                                      input logic hit,
                                      input logic used);
    write_open = strobe && hit && !used;
  endfunction : write_open

  // general resets act on any reset, including power-on
  // both reset pins are asynchronous and join for every flop except the voltage mode pair, which sees por_arst_n alone
  logic rst_all_n;
  assign rst_all_n = arst_n & por_arst_n;

  // option latches and their write-used flags
  // one register's used flag never blocks the other register
  logic [7:0] opt_one_r;  // all bits except the voltage mode
  logic [7:0] opt_one_nxt;
  logic [7:0] opt_two_r;
  logic [7:0] opt_two_nxt;
  logic one_used_r;  // first write to reg one taken
  logic one_used_nxt;
  logic two_used_r;
  logic two_used_nxt;
  // voltage mode bit lives in the power-on reset domain
  logic lv_mode_r;
  logic lv_mode_nxt;
  logic lv_used_r;
  logic lv_used_nxt;
  // read data register
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  // clock output divider
  logic [1:0] div_cnt_r;
  logic [1:0] div_cnt_nxt;
  logic clk_tick_r;
  logic clk_tick_nxt;

  // address decode, shared by the write and read paths
  // a narrow bus compares only the bits it carries
  logic hit_one;
  logic hit_two;
  assign hit_one = addr_hit(addr, OPT_ONE_ADDR);
  assign hit_two = addr_hit(addr, OPT_TWO_ADDR);

  // reg one as seen by software, voltage mode merged in
  // the merged view is what a read of register one returns
  logic [7:0] opt_one_view;
  always_comb begin
    opt_one_view = opt_one_r;
    opt_one_view[LV_MODE_BIT] = lv_mode_r;
  end

  // next values of register one, register two and their used flags
  always_comb begin
    opt_one_nxt = opt_one_r;
    opt_two_nxt = opt_two_r;
    one_used_nxt = one_used_r;
    two_used_nxt = two_used_r;
    // only the first write after reset lands; later ones drop
    if (write_open(wr, hit_one, one_used_r)) begin
      opt_one_nxt = wdata;
      // the mode bit is held apart, this copy stays zero
      opt_one_nxt[LV_MODE_BIT] = 1'b0;
      one_used_nxt = 1'b1;
    end
    // register two keeps only its implemented bits
    if (write_open(wr, hit_two, two_used_r)) begin
      opt_two_nxt = wdata & OPT_TWO_MASK;
      two_used_nxt = 1'b1;
    end
  end

  // next value of the voltage mode bit, armed once per power-on
  always_comb begin
    lv_mode_nxt = lv_mode_r;
    lv_used_nxt = lv_used_r;
    // a plain reset does not rearm this write, so it may stay used
    if (write_open(wr, hit_one, lv_used_r)) begin
      lv_mode_nxt = wdata[LV_MODE_BIT];
      lv_used_nxt = 1'b1;
    end
  end

  // option latches cleared by any reset; defaults need no software write
  // and both register write flags are rearmed here, but not the voltage mode one
  always_ff @(posedge clk or negedge rst_all_n) begin
    if (!rst_all_n) begin
      opt_one_r <= OPT_RESET_VAL;
      opt_two_r <= OPT_RESET_VAL;
      one_used_r <= 1'b0;
      two_used_r <= 1'b0;
    end else if (ce) begin
      opt_one_r <= opt_one_nxt;
      opt_two_r <= opt_two_nxt;
      one_used_r <= one_used_nxt;
      two_used_r <= two_used_nxt;
    end
  end

  // voltage mode latch cleared only by power-on reset; a plain reset
  // must not reach it, or the monitor would fall back to its default mode
  always_ff @(posedge clk or negedge por_arst_n) begin
    if (!por_arst_n) begin
      lv_mode_r <= 1'b0;
      lv_used_r <= 1'b0;
    end else if (ce) begin
      lv_mode_r <= lv_mode_nxt;
      lv_used_r <= lv_used_nxt;
    end
  end

  // read path, answer in the cycle after the strobe; idle and unmapped
  // cycles answer zero so the data can be merged onto a shared read bus
  always_comb begin
    rdata_nxt = READ_UNMAPPED;
    if (rd && hit_one) begin
      rdata_nxt = opt_one_view;
    end else if (rd && hit_two) begin
      rdata_nxt = opt_two_r;
    end
  end

  // read data register, zero outside the answer cycle
  // and frozen with the rest of the state while ce is low
  always_ff @(posedge clk or negedge rst_all_n) begin
    if (!rst_all_n) begin
      rdata_r <= READ_UNMAPPED;
    end else if (ce) begin
      rdata_r <= rdata_nxt;
    end
  end

  // read data straight from its flop
  assign rdata = rdata_r;

  // selected source for the clock output
  // clkout_source_sel set picks the crystal ticks, clear the bus ticks
  logic src_tick;
  logic [1:0] div_code;
  always_comb begin
    src_tick = opt_two_r[CLK_SRC_BIT] ? osc_tick : bus_tick;
    div_code = {opt_two_r[CLK_DIV_HI_BIT], opt_two_r[CLK_DIV_LO_BIT]};
  end

  // divide the selected ticks by one, two or four; the divider counts
  // source ticks, not clk edges, so its output is a one-cycle pulse
  // train rather than a square wave, and downstream logic must treat
  // it as an enable
  always_comb begin
    div_cnt_nxt = div_cnt_r;
    clk_tick_nxt = 1'b0;
    case (div_code)
      CLKOUT_OFF: begin
        // output off: park the count so a later enable starts clean
        div_cnt_nxt = 2'd0;
      end
      CLKOUT_DIV1: begin
        // every selected tick passes straight through
        div_cnt_nxt = 2'd0;
        clk_tick_nxt = src_tick;
      end
      CLKOUT_DIV2: begin
        // toggle the low count bit, pulse on every second tick
        if (src_tick) begin
          div_cnt_nxt = {1'b0, ~div_cnt_r[0]};
          clk_tick_nxt = div_cnt_r[0];
        end
      end
      default: begin
        // divide by four: pulse when the count wraps
        if (src_tick) begin
          div_cnt_nxt = div_cnt_r + 2'd1;
          clk_tick_nxt = (div_cnt_r == 2'd3);
        end
      end
    endcase
  end

  // divider state, cleared by any reset so the first pulse after reset
  // comes only after a full divide period
  always_ff @(posedge clk or negedge rst_all_n) begin
    if (!rst_all_n) begin
      div_cnt_r <= 2'd0;
      clk_tick_r <= 1'b0;
    end else if (ce) begin
      div_cnt_r <= div_cnt_nxt;
      clk_tick_r <= clk_tick_nxt;
    end
  end

  // clock output enable straight from its flop
  assign clkout_tick = clk_tick_r;

  // field outputs straight from the latches; they change only on the
  // one accepted write or on reset, so consumers see steady levels
  assign watchdog_rate_sel = opt_one_r[WD_RATE_BIT];
  assign lowvolt_stop_en = opt_one_r[LV_STOP_BIT];
  assign lowvolt_reset_dis = opt_one_r[LV_RSTD_BIT];
  assign lowvolt_power_dis = opt_one_r[LV_PWRD_BIT];
  assign lowvolt_mode_sel = lv_mode_r;
  assign short_recovery_sel = opt_one_r[SHORT_REC_BIT];
  assign stop_insn_en = opt_one_r[STOP_EN_BIT];
  assign watchdog_dis = opt_one_r[WD_DIS_BIT];
  assign clkout_source_sel = opt_two_r[CLK_SRC_BIT];
  assign clkout_div_hi = opt_two_r[CLK_DIV_HI_BIT];
  assign clkout_div_lo = opt_two_r[CLK_DIV_LO_BIT];
  assign timebase_presc_en = opt_two_r[TB_PRESC_BIT];
  assign osc_in_stop_en = opt_two_r[OSC_STOP_BIT];
  assign sci_clk_src_sel = opt_two_r[SCI_SRC_BIT];
  assign opt_one_locked = one_used_r;
  assign opt_two_locked = two_used_r;

  // stop exit delay chosen by the short recovery bit
  // counts are in osc_clock cycles; the stop logic loads them as they are
  assign stop_recovery_cycles = opt_one_r[SHORT_REC_BIT] ?
                                STOP_REC_SHORT : STOP_REC_LONG;

  // watchdog timeout chosen by the rate bit
  // also in osc_clock cycles, decoded from the latch with no extra flop
  assign watchdog_timeout_cycles = opt_one_r[WD_RATE_BIT] ?
                                   WD_TIMEOUT_FAST :
                                   WD_TIMEOUT_SLOW;

endmodule : write_once_option_registers

// ### sim/option_regs_sva.sv
// checker for the write-once option register bank
`timescale 1ns/1ns
module option_regs_sva
  import option_regs_pkg::*;
#(
  parameter int ADDR_W = 16
) (
  // clock, resets, enable
  input wire logic clk,
  input wire logic arst_n,
  input wire logic por_arst_n,
  input wire logic ce,
  // register port
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [DATA_W-1:0] rdata,
  // clock sources
  input wire logic osc_tick,
  input wire logic bus_tick,
  // option fields and status
  input wire logic watchdog_rate_sel,
  input wire logic short_recovery_sel,
  input wire logic clkout_source_sel,
  input wire logic clkout_div_hi,
  input wire logic clkout_div_lo,
  input wire logic timebase_presc_en,
  input wire logic osc_in_stop_en,
  input wire logic sci_clk_src_sel,
  input wire logic [12:0] stop_recovery_cycles,
  input wire logic [17:0] watchdog_timeout_cycles,
  input wire logic opt_two_locked,
  input wire logic clkout_tick
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n || !por_arst_n);
  // second register as software reads it
  wire [7:0] two_w = {clkout_source_sel, clkout_div_hi, clkout_div_lo, 1'b0,
    timebase_presc_en, 1'b0, osc_in_stop_en, sci_clk_src_sel};
  wire [1:0] code_w = {clkout_div_hi, clkout_div_lo};
  // tick of the selected clock source
  wire src_w = ce && (clkout_source_sel ? osc_tick : bus_tick);
  sequence rd_two_s;
    ce && rd && addr == OPT_TWO_ADDR;
  endsequence
  sequence wr_two_s;
    ce && wr && addr == OPT_TWO_ADDR && !opt_two_locked;
  endsequence
  read_idle_a: assert property (ce && !rd |=> rdata == 8'h00)
    else $error("read data outside read slot");
  read_two_a: assert property (rd_two_s |=> rdata == $past(two_w))
    else $error("register two read wrong");
  write_two_a: assert property (wr_two_s |=> opt_two_locked &&
    two_w == ($past(wdata) & OPT_TWO_MASK)) else $error("first write lost");
  lock_two_a: assert property (opt_two_locked |=> $stable(two_w))
    else $error("locked register changed");
  stop_delay_a: assert property (stop_recovery_cycles ==
    (short_recovery_sel ? STOP_REC_SHORT : STOP_REC_LONG))
    else $error("stop delay");
  wd_timeout_a: assert property (watchdog_timeout_cycles ==
    (watchdog_rate_sel ? WD_TIMEOUT_FAST : WD_TIMEOUT_SLOW))
    else $error("timeout");
  clkout_off_a: assert property (
    (code_w == CLKOUT_OFF)[*2] |-> !clkout_tick)
    else $error("pulse while output off");
  clkout_div1_a: assert property (
    code_w == CLKOUT_DIV1 && src_w |=> clkout_tick)
    else $error("undivided pulse missing");
  clkout_div4_a: assert property (clkout_tick && code_w == CLKOUT_DIV4
    |=> (!clkout_tick)[*3]) else $error("divide by four too fast");
endmodule : option_regs_sva

bind write_once_option_registers option_regs_sva #(.ADDR_W(ADDR_W)) sva (.*);

// ### sim/testbench.sv
// random and corner stimulus for the option register bank
`timescale 1ns/1ns
module testbench
  import option_regs_pkg::*;
;
  // design ports
  logic clk, arst_n, por_arst_n, ce, wr, rd, osc_tick, bus_tick;
  logic [15:0] addr;
  logic [7:0] wdata, rdata;
  logic watchdog_rate_sel, lowvolt_stop_en, lowvolt_reset_dis;
  logic lowvolt_power_dis, lowvolt_mode_sel, short_recovery_sel;
  logic stop_insn_en, watchdog_dis, clkout_source_sel, clkout_div_hi;
  logic clkout_div_lo, timebase_presc_en, osc_in_stop_en, sci_clk_src_sel;
  logic opt_one_locked, opt_two_locked, clkout_tick;
  logic [12:0] stop_recovery_cycles;
  logic [17:0] watchdog_timeout_cycles;
  // bench state
  int n_errors = 0;
  int compares = 0;
  int n;
  logic [31:0] seed = 32'h0000_0056;
  logic [7:0] v1, v2;
  logic lv, armed;
  // derived delays packed as delays() packs them
  logic [30:0] dly;
  // reg one field outputs in register bit order
  logic [7:0] one_f;
  assign dly = {stop_recovery_cycles, watchdog_timeout_cycles};
  assign one_f = {watchdog_rate_sel, lowvolt_stop_en, lowvolt_reset_dis,
    lowvolt_power_dis, lowvolt_mode_sel, short_recovery_sel, stop_insn_en,
    watchdog_dis};
  write_once_option_registers dut (.*);
  // 50 ns clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction : rnd
  // expected stop delay and watchdog timeout side by side
  function automatic logic [30:0] delays(input logic [7:0] v);
    return {v[SHORT_REC_BIT] ? STOP_REC_SHORT : STOP_REC_LONG,
      v[WD_RATE_BIT] ? WD_TIMEOUT_FAST : WD_TIMEOUT_SLOW};
  endfunction : delays
  // pulses expected from sixteen source ticks
  function automatic int pulses(input logic [1:0] c);
    return (c == CLKOUT_OFF) ? 0 : (16 >> (c - 2'h1));
  endfunction : pulses
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch at %0t: saw %0h, expected %0h", $time, seen, exp);
    end
  endtask : check
  task automatic stop_test();
    if (n_errors == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : stop_test
  task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [15:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    check(rdata, exp);
  endtask : rd_reg
  // power-on reset when por is set, plain reset otherwise
  task automatic reset_pulse(input logic por);
    @(posedge clk);
    arst_n <= por;
    por_arst_n <= !por;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    por_arst_n <= 1'b1;
  endtask : reset_pulse
  // cut a hang short
  initial begin
    #2_000_000;
    n_errors++;
    stop_test();
  end
  initial begin
    {arst_n, por_arst_n, wr, rd, osc_tick, bus_tick} = 6'h00;
    ce = 1'b1;
    addr = 16'h0000;
    wdata = 8'h00;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    por_arst_n <= 1'b1;
    check(dly, delays(8'h00));
    check({one_f, opt_one_locked, opt_two_locked}, 32'h0000_0000);
    rd_reg(OPT_TWO_ADDR, OPT_RESET_VAL);
    lv = 1'b0;
    armed = 1'b1;
    // first write sticks, second is dropped, resets alternate
    for (int i = 0; i < 6; i++) begin
      v1 = (i == 0) ? 8'hFF : rnd();
      v2 = (i == 0) ? 8'hFF : rnd();
      if (i == 1) v1[LV_MODE_BIT] = 1'b0;
      if (armed) lv = v1[LV_MODE_BIT];
      armed = 1'b0;
      // a write while the clock enable is low must neither land nor lock
      @(posedge clk);
      ce <= 1'b0;
      wr_reg(OPT_TWO_ADDR, ~v2);
      ce <= 1'b1;
      @(negedge clk);
      check(opt_two_locked, 1'b0);
      wr_reg(OPT_ONE_ADDR, v1);
      wr_reg(OPT_TWO_ADDR, v2);
      wr_reg(OPT_ONE_ADDR, ~v1);
      wr_reg(OPT_TWO_ADDR, ~v2);
      rd_reg(OPT_ONE_ADDR, {v1[7:4], lv, v1[2:0]});
      rd_reg(OPT_TWO_ADDR, v2 & OPT_TWO_MASK);
      rd_reg(16'h0020, READ_UNMAPPED);
      check(dly, delays(v1));
      check(one_f, {v1[7:4], lv, v1[2:0]});
      check({opt_one_locked, opt_two_locked}, 2'h3);
      reset_pulse(i[0]);
      armed = i[0];
      lv = lv & !i[0];
      rd_reg(OPT_ONE_ADDR, {4'h0, lv, 3'h0});
      check(one_f, {4'h0, lv, 3'h0});
      check({opt_one_locked, opt_two_locked}, 2'h0);
    end
    // every source and divide code over sixteen selected ticks
    for (int s = 0; s < 2; s++) begin
      for (int c = 0; c < 4; c++) begin
        reset_pulse(1'b1);
        wr_reg(OPT_TWO_ADDR, {s[0], c[1:0], 5'h00});
        n = 0;
        for (int k = 0; k < 36; k++) begin
          @(posedge clk);
          osc_tick <= (k < 32) && (s == 0 || !k[0]);
          bus_tick <= (k < 32) && (s == 1 || !k[0]);
          @(negedge clk);
          n += (clkout_tick === 1'b1);
        end
        check(n, pulses(c[1:0]));
      end
    end
    stop_test();
  end
endmodule : testbench
